// >>> common/page_select_pkg.sv
package page_select_pkg;
   localparam int          PORT_COUNT     = 4;
   localparam int          SOURCE_COUNT   = 5;   // local i2c + one per port
   localparam logic [7:0]  OFFS_EMBED     = 8'h4B;
   localparam logic [7:0]  OFFS_PAGE_SEL  = 8'h4C;
   localparam logic [7:0]  OFFS_STATUS1   = 8'h4D;
   localparam logic [7:0]  PAGED_LO_A     = 8'h4D;
   localparam logic [7:0]  PAGED_HI_A     = 8'h7F;
   localparam logic [7:0]  PAGED_LO_B     = 8'hD0;
   localparam logic [7:0]  PAGED_HI_B     = 8'hDF;
   localparam logic [5:0]  RST_EMBED_CODE = 6'h12;
   localparam logic [1:0]  RST_LINE_COUNT = 2'h0;
   localparam logic [1:0]  RST_READ_PORT  = 2'h0;
   localparam logic [3:0]  RST_WRITE_EN   = 4'h0;
   localparam logic [1:0]  RST_LINES_SEEN = 2'h0;
   localparam int          FIELD_PHYS_LSB = 6;
   localparam int          FIELD_READ_LSB = 4;
   localparam int          FIELD_WEN_LSB  = 0;
   localparam int          FIELD_CNT_LSB  = 6;
   localparam int          FIELD_CODE_LSB = 0;
   localparam int          FIELD_STS_LSB  = 6;
   localparam logic [2:0]  SRC_LOCAL      = 3'h0;

   // one host access from a given source
   typedef struct packed {
      logic       valid;
      logic       write;
      logic [2:0] source;  // 0 local i2c, 1..4 control channel of port n-1
      logic [7:0] addr;
      logic [7:0] wdata;
   } host_req_t;

   // read answer
   typedef struct packed {
      logic       valid;
      logic [7:0] rdata;
   } host_rsp_t;

   // per-source page selection
   typedef struct packed {
      logic [1:0] read_port;
      logic [3:0] write_en;
   } page_sel_t;

   // packet tagging request from the receive datapath
   typedef struct packed {
      logic       valid;
      logic [1:0] port;
      logic       frame_start;
      logic       long_packet;
      logic       raw_twelve;
      logic       csi_mode;
      logic [5:0] raw_ten_type_code;
      logic [5:0] raw_twelve_type_code;
   } pkt_req_t;

   typedef struct packed {
      logic       valid;
      logic       embedded;
      logic [5:0] data_type;
   } pkt_rsp_t;
endpackage

// >>> verification/host_model.sv
`timescale 1ns/100ps
// host on local i2c or on a port's control channel
module host_model (
   // clock
   input  wire logic                       mclk,
   // device answer and request
   input  wire page_select_pkg::host_rsp_t host_rsp,
   output page_select_pkg::host_req_t      host_req
);
   initial host_req = '0;
   // one strobe, then fields inverted so stale values never look valid
   task automatic access(input logic [2:0] s, input logic w,
                         input logic [7:0] a, d, output logic [8:0] r);
      @(posedge mclk);
      host_req <= '{1'b1, w, s, a, d};
      @(posedge mclk);
      host_req <= '{1'b0, ~w, ~s, ~a, ~d};
      @(posedge mclk);
      r = {host_rsp.valid, host_rsp.rdata};
   endtask
endmodule // host_model

// >>> verification/page_select_assertions.sv
`timescale 1ns/100ps
module page_select_assertions (
   input wire logic                       mclk,
   input wire logic                       srst,
   input wire page_select_pkg::host_req_t host_req,
   input wire page_select_pkg::host_rsp_t host_rsp,
   input wire page_select_pkg::pkt_req_t  pkt_req,
   input wire page_select_pkg::pkt_rsp_t  pkt_rsp
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);
   // accepted read strobe and its address
   wire       rd = host_req.valid && !host_req.write && host_req.source < 3'h5;
   wire [7:0] ad = host_req.addr;
   // host answer timing and contents
   a_read_answered: assert property (rd |=> host_rsp.valid)
      else $error("read not answered");
   a_write_silent: assert property (host_req.valid && host_req.write
      |=> !host_rsp.valid) else $error("write answered");
   a_idle_rdata_zero: assert property (!host_rsp.valid |->
      host_rsp.rdata == 8'h00) else $error("rdata not zero");
   a_local_phys_zero: assert property (rd && host_req.source == 3'h0 &&
      ad == 8'h4C |=> host_rsp.rdata[7:6] == 2'h0) else $error("phys local");
   a_remote_phys: assert property (rd && host_req.source != 3'h0 &&
      ad == 8'h4C |=> host_rsp.rdata[7:6] ==
      2'($past(host_req.source) - 3'h1)) else $error("phys remote");
   a_status_low_zero: assert property (rd && ad == 8'h4D
      |=> host_rsp.rdata[5:0] == 6'h00) else $error("status low");
   a_unmapped_zero: assert property (rd && ad inside {[8'h4E:8'h7F],
      [8'hD0:8'hDF]} |=> host_rsp.rdata == 8'h00) else $error("unmapped");
   // packet tagging
   a_csi_raw: assert property (pkt_req.valid && pkt_req.csi_mode
      |=> pkt_rsp.valid && !pkt_rsp.embedded) else $error("csi tagged");
   a_frame_start_raw: assert property (pkt_req.valid &&
      pkt_req.frame_start && !pkt_req.raw_twelve |=>
      pkt_rsp.data_type == $past(pkt_req.raw_ten_type_code))
      else $error("frame start type");
endmodule // page_select_assertions

bind rx_port_page_select page_select_assertions u_page_select_assertions (
   .mclk(mclk), .srst(srst), .host_req(host_req), .host_rsp(host_rsp),
   .pkt_req(pkt_req), .pkt_rsp(pkt_rsp));

// >>> verification/tb_rx_port_page_select.sv
`timescale 1ns/100ps
module tb_rx_port_page_select;
   logic                       mclk = 1'b0;
   logic                       srst = 1'b1;
   page_select_pkg::host_req_t host_req;
   page_select_pkg::host_rsp_t host_rsp;
   page_select_pkg::pkt_req_t  pkt_req = '0;
   page_select_pkg::pkt_rsp_t  pkt_rsp;
   int                         errors = 0;
   int                         check_count = 0;
   logic [7:0]                 page [4];
   logic [8:0]                 r;
   always #5 mclk = ~mclk;
   rx_port_page_select u_rx_port_page_select (.mclk(mclk), .srst(srst),
      .host_req(host_req), .host_rsp(host_rsp), .pkt_req(pkt_req),
      .pkt_rsp(pkt_rsp));
   host_model u_host_model (.mclk(mclk), .host_rsp(host_rsp),
      .host_req(host_req));
   // compare and count
   task automatic chk(string n, logic [8:0] e, logic [8:0] s);
      check_count++;
      if (s !== e) begin
         errors++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic rd(logic [2:0] s, logic [7:0] a, logic [7:0] e);
      u_host_model.access(s, 1'b0, a, 8'h00, r);
      chk("rdata", {1'b1, e}, r);
   endtask
   task automatic wr(logic [2:0] s, logic [7:0] a, logic [7:0] d);
      u_host_model.access(s, 1'b1, a, d, r);
   endtask
   // expected {valid, embedded, type} of packet i of a frame
   function automatic logic [7:0] exp_tag(int i, logic c, logic [7:0] v,
                                          logic [5:0] raw);
      if (!c && i > 0 && i <= int'(v[7:6])) return {2'h3, v[5:0]};
      return {2'h2, raw};
   endfunction
   task automatic summarize;
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // hang guard
   initial begin
      repeat (50000) @(posedge mclk);
      errors++;
      summarize;
   end
   // main sequence
   initial begin
      logic [7:0] m, v;
      int c, t;
      c = $urandom(44);
      repeat (5) @(posedge mclk);
      srst <= 1'b0;
      rd(0, 8'h4C, 8'h00);
      for (int s = 1; s < 5; s++) begin
         t = s - 1;
         rd(3'(s), 8'h4C, {t[1:0], t[1:0], 4'(1 << t)});
      end
      rd(0, 8'h4B, 8'h12);
      $display("defaults test done");
      for (int p = 0; p < 4; p++) page[p] = 8'h12;
      wr(0, 8'h4C, 8'h00);
      wr(0, 8'h4B, 8'h3F);
      for (int i = 0; i < 6; i++) begin
         m = (i == 5) ? 8'h0F : 8'($urandom) & 8'h0F;
         v = 8'($urandom);
         wr(0, 8'h4C, m);
         wr(0, 8'h4B, v);
         for (int p = 0; p < 4; p++) if (m[p]) page[p] = v;
         for (int p = 0; p < 4; p++) begin
            wr(0, 8'h4C, {2'h0, 2'(p), 4'h0});
            rd(0, 8'h4B, page[p]);
            rd(0, 8'h4D, {2'(p), 6'h00});
         end
      end
      rd(2, 8'h4D, 8'h40);
      wr(3, 8'h4C, 8'h20);
      rd(3, 8'h4C, 8'hA0);
      rd(3, 8'h4D, 8'h80);
      rd(2, 8'h4D, 8'h40);
      rd(0, 8'h4D, 8'hC0);
      rd(5, 8'h4C, 8'h00);
      m = 8'h4E + 8'($urandom % 50);
      rd(0, m, 8'h00);
      rd(0, 8'hD0 | (8'($urandom) & 8'h0F), 8'h00);
      $display("paging test done");
      for (int p = 0; p < 4; p++) for (int n = 0; n < 4; n++) begin
         v = {2'(n), 6'($urandom)};
         c = $urandom;
         wr(0, 8'h4C, 8'(1 << p));
         wr(0, 8'h4B, v);
         for (int k = 0; k < 7; k++) begin
            @(posedge mclk);
            pkt_req <= '{1'b1, 2'(p), k % 5 == 0, k % 5 != 0, c[12],
                         k == 6, c[5:0], c[11:6]};
            @(posedge mclk);
            pkt_req <= '0;
            @(posedge mclk);
            chk("tag", {1'b0, exp_tag(k % 5, k == 6, v,
               c[12] ? c[11:6] : c[5:0])}, {1'b0, pkt_rsp});
         end
      end
      $display("tagging test done");
      summarize;
   end
endmodule // tb_rx_port_page_select

// >>> verilog/rx_port_page_select.sv
`timescale 1ns/100ps

module rx_port_page_select #(
   parameter int PORTS = page_select_pkg::PORT_COUNT
) (
   // clock and reset
   input  wire logic                       mclk,
   input  wire logic                       srst,
   // host register access
   input  wire page_select_pkg::host_req_t host_req,
   output page_select_pkg::host_rsp_t      host_rsp,
   // receive datapath packet tagging
   input  wire page_select_pkg::pkt_req_t  pkt_req,
   output page_select_pkg::pkt_rsp_t       pkt_rsp
);
   localparam int SRCS = page_select_pkg::SOURCE_COUNT;

   // per-port page storage and per-source selection
   logic [1:0]                  line_count_ff [PORTS];
   logic [1:0]                  nxt_line_count [PORTS];
   logic [5:0]                  type_code_ff [PORTS];
   logic [5:0]                  nxt_type_code [PORTS];
   logic [1:0]                  lines_seen_ff [PORTS];
   logic [1:0]                  nxt_lines_seen [PORTS];
   page_select_pkg::page_sel_t  sel_ff [SRCS];
   page_select_pkg::page_sel_t  nxt_sel [SRCS];
   page_select_pkg::host_rsp_t  nxt_host_rsp;
   page_select_pkg::pkt_rsp_t   nxt_pkt_rsp;
   // decode of the current host access
   logic                        src_ok;
   page_select_pkg::page_sel_t  cur_sel;
   logic [1:0]                  rd_port;

   // receive port that carries a control channel source
   function automatic logic [1:0] src_port(input logic [2:0] src);
      return 2'(src - 3'h1);
   endfunction

   // reset value of one source's selection
   function automatic page_select_pkg::page_sel_t sel_default(
      input logic [2:0] src);
      page_select_pkg::page_sel_t d;
      d.read_port = page_select_pkg::RST_READ_PORT;
      d.write_en  = page_select_pkg::RST_WRITE_EN;
      // a control channel source starts on its own port
      if (src != page_select_pkg::SRC_LOCAL) begin
         d.read_port = src_port(src);
         d.write_en  = 4'(4'h1 << src_port(src));
      end
      return d;
   endfunction

   // true for the per-port address windows
   function automatic logic is_paged(input logic [7:0] a);
      return (a >= page_select_pkg::PAGED_LO_A &&
              a <= page_select_pkg::PAGED_HI_A) ||
             (a >= page_select_pkg::PAGED_LO_B &&
              a <= page_select_pkg::PAGED_HI_B) ||
             a == page_select_pkg::OFFS_EMBED;
   endfunction

   // the requesting source's selection, zero beyond the last source
   always_comb begin
      src_ok  = host_req.source < 3'(SRCS);
      cur_sel = '0;
      if (src_ok) begin
         cur_sel = sel_ff[host_req.source];
      end
      rd_port = cur_sel.read_port;
   end

   // page select writes, each source keeps its own copy
   always_comb begin
      for (int s = 0; s < SRCS; s++) begin
         nxt_sel[s] = sel_ff[s];
      end
      if (host_req.valid && host_req.write && src_ok &&
          host_req.addr == page_select_pkg::OFFS_PAGE_SEL) begin
         // the physical index bits are read only and dropped here
         nxt_sel[host_req.source].read_port =
            host_req.wdata[page_select_pkg::FIELD_READ_LSB +: 2];
         nxt_sel[host_req.source].write_en  =
            host_req.wdata[page_select_pkg::FIELD_WEN_LSB +: 4];
      end
   end

   // selection registers
   always_ff @(posedge mclk) begin
      if (srst) begin
         for (int s = 0; s < SRCS; s++) begin
            sel_ff[s] <= sel_default(3'(s));
         end
      end else begin
         sel_ff <= nxt_sel;
      end
   end

   // embed register writes land in every enabled port page at once
   always_comb begin
      for (int p = 0; p < PORTS; p++) begin
         nxt_line_count[p] = line_count_ff[p];
         nxt_type_code[p]  = type_code_ff[p];
         if (host_req.valid && host_req.write && src_ok &&
             cur_sel.write_en[p] &&
             host_req.addr == page_select_pkg::OFFS_EMBED) begin
            nxt_line_count[p] =
               host_req.wdata[page_select_pkg::FIELD_CNT_LSB +: 2];
            nxt_type_code[p]  =
               host_req.wdata[page_select_pkg::FIELD_CODE_LSB +: 6];
         end
      end
   end

   // page storage, a packet in the write cycle still sees the old page
   always_ff @(posedge mclk) begin
      if (srst) begin
         for (int p = 0; p < PORTS; p++) begin
            line_count_ff[p] <= page_select_pkg::RST_LINE_COUNT;
            type_code_ff[p]  <= page_select_pkg::RST_EMBED_CODE;
         end
      end else begin
         line_count_ff <= nxt_line_count;
         type_code_ff  <= nxt_type_code;
      end
   end

   // read answer from the selection or from the read port's page
   always_comb begin
      logic [7:0] rd;
      rd = 8'h00;
      nxt_host_rsp.valid = host_req.valid && !host_req.write;
      if (nxt_host_rsp.valid && src_ok) begin
         if (host_req.addr == page_select_pkg::OFFS_PAGE_SEL) begin
            if (host_req.source != page_select_pkg::SRC_LOCAL) begin
               rd[page_select_pkg::FIELD_PHYS_LSB +: 2] =
                  src_port(host_req.source);
            end
            rd[page_select_pkg::FIELD_READ_LSB +: 2] = cur_sel.read_port;
            rd[page_select_pkg::FIELD_WEN_LSB +: 4]  = cur_sel.write_en;
         end else if (is_paged(host_req.addr)) begin
            if (host_req.addr == page_select_pkg::OFFS_EMBED) begin
               rd = {line_count_ff[rd_port], type_code_ff[rd_port]};
            end else if (host_req.addr == page_select_pkg::OFFS_STATUS1) begin
               rd[page_select_pkg::FIELD_STS_LSB +: 2] = rd_port;
            end
         end
      end
      // idle cycles and unmapped offsets read as zero
      nxt_host_rsp.rdata = rd;
   end

   // answer register
   always_ff @(posedge mclk) begin
      if (srst) begin
         host_rsp <= '0;
      end else begin
         host_rsp <= nxt_host_rsp;
      end
   end

   // per-frame long packet substitution
   always_comb begin
      for (int p = 0; p < PORTS; p++) begin
         nxt_lines_seen[p] = lines_seen_ff[p];
      end
      nxt_pkt_rsp.valid     = pkt_req.valid;
      nxt_pkt_rsp.embedded  = 1'b0;
      nxt_pkt_rsp.data_type = pkt_req.raw_twelve ?
         pkt_req.raw_twelve_type_code : pkt_req.raw_ten_type_code;
      // a new frame restarts the count, its own answer stays raw
      if (pkt_req.valid && pkt_req.frame_start) begin
         nxt_lines_seen[pkt_req.port] = page_select_pkg::RST_LINES_SEEN;
      end else if (pkt_req.valid && pkt_req.long_packet &&
                   !pkt_req.csi_mode) begin
         if (lines_seen_ff[pkt_req.port] < line_count_ff[pkt_req.port]) begin
            nxt_pkt_rsp.embedded  = 1'b1;
            nxt_pkt_rsp.data_type = type_code_ff[pkt_req.port];
            nxt_lines_seen[pkt_req.port] =
               2'(lines_seen_ff[pkt_req.port] + 2'h1);
         end
      end
   end

   // packet counters and answer register
   always_ff @(posedge mclk) begin
      if (srst) begin
         for (int p = 0; p < PORTS; p++) begin
            lines_seen_ff[p] <= page_select_pkg::RST_LINES_SEEN;
         end
         pkt_rsp <= '0;
      end else begin
         lines_seen_ff <= nxt_lines_seen;
         pkt_rsp       <= nxt_pkt_rsp;
      end
   end
endmodule // rx_port_page_select
